// *** rtl/rgd_regs.sv ***
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "rgd_cfg.svh"

// How it works
// - Preamble word reads 0xB1, ignores writes
// - Identification word reads zero when scheme absent
// - Affinity copy present only when group tied
// - Level-0 layout places four affinity bytes
// - Bit 31 flags level-zero affinity valid
// - Uniprocessor and interdependence bits, level zero
// - Level-3 layout bits 23:16 read 0x80
// - Level-2/3 bits 15:8 flag level two
// - Level-1/2/3 bits 7:0 flag level one
// - Architecture word present when enabled, bit 20; reads zero when absent
// - Architect field holds fixed designer code
// - Revision and version fields read zero
// - Low twelve bits hold fixed part code
// - Group status bit is record valid flag ANDed with summary support
// - Absent or unsupported records read zero
// - Record count reports highest index plus one
// - Sixteen 64-bit read/write interrupt slots
// - Recommended layout: status word in slot 15
module rgd_regs #(
	parameter bit CID_PRESENT = 1'b1,
	parameter bit AFF_PRESENT = 1'b1,
	parameter rgd_pkg::rgd_layout_t AFF_LAYOUT = rgd_pkg::RGD_LAYOUT_L0,
	parameter bit ARCH_PRESENT = 1'b1,
	// Arbitrary designer code
	parameter logic [10:0] ARCH_DESIGNER = 11'h15a,
	// Arbitrary part code
	parameter logic [11:0] ARCH_PART = 12'h5c3,
	parameter bit IRQ_PRESENT = 1'b1,
	parameter bit IRQ_RECOMMENDED = 1'b1
) (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [11:0] awaddr,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [11:0] araddr,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Processor affinity
	input wire logic [7:0] affinity_level_zero,
	input wire logic [7:0] affinity_level_one,
	input wire logic [7:0] affinity_level_two,
	input wire logic [7:0] affinity_level_three,
	input wire logic level_zero_valid_flag,
	input wire logic affinity_level_one_valid,
	input wire logic affinity_level_two_valid,
	input wire logic uniprocessor_flag,
	input wire logic threaded_interdependence_flag,
	// Error records
	input wire logic [`RGD_NUM_RECORDS-1:0] record_valid,
	input wire logic [`RGD_NUM_RECORDS-1:0] record_summary_support,
	// Interrupt write engine
	input wire logic fhi_write_busy,
	input wire logic eri_write_busy,
	input wire logic fhi_write_error,
	input wire logic eri_write_error,
	output logic [127:0] fault_handling_irq_config,
	output logic [127:0] error_recovery_irq_config
);
	import rgd_pkg::*;

	localparam int GSR_COUNT = (`RGD_NUM_RECORDS + `RGD_GSR_BITS - 1) / `RGD_GSR_BITS;
	localparam int SUM_BITS = `RGD_GSR_MAX * `RGD_GSR_BITS;

	function automatic rgd_decode_t decode(input logic [11:0] addr);
		rgd_decode_t d;
		d.region = RGD_REG_NONE;
		d.index = addr[6:3];
		d.hi = addr[2];
		if (addr[11:7] == `RGD_WIN_GSR) begin
			if (32'(addr[6:3]) < GSR_COUNT) begin
				d.region = RGD_REG_GSR;
			end
		end else if (addr[11:7] == `RGD_WIN_IRQ) begin
			d.region = RGD_REG_IRQ;
		end else if (addr[11:3] == `RGD_OFF_AFF >> 3) begin
			d.region = RGD_REG_AFF;
		end else if (addr == `RGD_OFF_ARCH) begin
			d.region = RGD_REG_ARCH;
		end else if (addr == `RGD_OFF_IDR) begin
			d.region = RGD_REG_IDR;
		end else if (addr == `RGD_OFF_CID3) begin
			d.region = RGD_REG_CID3;
		end
		return d;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = din[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Group status summary, padded with zeros up to the full window
	logic [SUM_BITS-1:0] summary;

	genvar g;
	generate
		for (g = 0; g < SUM_BITS; g++) begin : g_sum
			if (g < `RGD_NUM_RECORDS) begin : g_rec
				assign summary[g] = record_valid[g] & record_summary_support[g];
			end else begin : g_pad
				assign summary[g] = 1'b0;
			end
		end
	endgenerate

	// Affinity copy
	logic [63:0] aff_word;

	always_comb begin
		aff_word = 64'h0;
		if (AFF_PRESENT) begin
			aff_word[39:32] = affinity_level_three;
			case (AFF_LAYOUT)
				RGD_LAYOUT_L0: begin
					aff_word[23:16] = affinity_level_two;
					aff_word[15:8] = affinity_level_one;
					aff_word[7:0] = affinity_level_zero;
					aff_word[`RGD_AFF_ZERO_VALID_BIT] = level_zero_valid_flag;
					// Undefined when level zero invalid; driven as zero
					aff_word[`RGD_AFF_U_BIT] = level_zero_valid_flag & uniprocessor_flag;
					aff_word[`RGD_AFF_THREAD_BIT] = level_zero_valid_flag & threaded_interdependence_flag;
				end
				RGD_LAYOUT_L1: begin
					aff_word[23:16] = affinity_level_two;
					aff_word[15:8] = affinity_level_one;
					aff_word[7:0] = affinity_level_one_valid ? `RGD_FIELD_VALID : `RGD_FIELD_INVALID;
				end
				RGD_LAYOUT_L2: begin
					aff_word[23:16] = affinity_level_two;
					aff_word[15:8] = affinity_level_two_valid ? `RGD_FIELD_VALID : `RGD_FIELD_INVALID;
					aff_word[7:0] = affinity_level_one_valid ? `RGD_FIELD_VALID : `RGD_FIELD_INVALID;
				end
				RGD_LAYOUT_L3: begin
					aff_word[23:16] = `RGD_FIELD_VALID;
					aff_word[15:8] = affinity_level_two_valid ? `RGD_FIELD_VALID : `RGD_FIELD_INVALID;
					aff_word[7:0] = affinity_level_one_valid ? `RGD_FIELD_VALID : `RGD_FIELD_INVALID;
				end
				default: begin
					aff_word = 64'h0;
				end
			endcase
		end
	end

	// Architecture identity
	logic [31:0] arch_word;

	always_comb begin
		arch_word = 32'h0;
		if (ARCH_PRESENT) begin
			arch_word[31:21] = ARCH_DESIGNER;
			arch_word[`RGD_ARCH_PRESENT_BIT] = 1'b1;
			arch_word[19:16] = `RGD_ARCH_REVISION;
			arch_word[15:12] = `RGD_ARCH_VERSION;
			arch_word[11:0] = ARCH_PART;
		end
	end

	// Interrupt configuration storage
	logic [63:0] irq_slot [`RGD_IRQ_SLOTS];
	logic fhi_err;
	logic eri_err;
	logic [63:0] irq_status;

	always_comb begin
		irq_status = 64'h0;
		irq_status[`RGD_IRQ_FHI_BIT] = fhi_write_busy;
		irq_status[`RGD_IRQ_FHIERR_BIT] = fhi_err;
		irq_status[`RGD_IRQ_ERI_BIT] = eri_write_busy;
		irq_status[`RGD_IRQ_ERIERR_BIT] = eri_err;
	end

	assign fault_handling_irq_config = {irq_slot[1], irq_slot[0]};
	assign error_recovery_irq_config = {irq_slot[3], irq_slot[2]};

	// Write channel
	logic aw_held;
	logic [11:0] aw_addr;
	logic w_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	rgd_decode_t wdec;

	assign awready = ce & ~aw_held & ~bvalid;
	assign wready = ce & ~w_held & ~bvalid;
	assign do_write = ce & aw_held & w_held & ~bvalid;
	assign wdec = decode(aw_addr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 12'h0;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_addr <= awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= `RGD_RST_WORD;
			w_strb <= 4'h0;
		end else if (ce) begin
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `RGD_RESP_OKAY;
		end else if (ce) begin
			if (do_write) begin
				bvalid <= 1'b1;
				// Writes to read-only words are accepted and dropped
				bresp <= (wdec.region == RGD_REG_NONE) ? `RGD_RESP_DECERR : `RGD_RESP_OKAY;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	logic slot_write;
	assign slot_write = do_write & IRQ_PRESENT & (wdec.region == RGD_REG_IRQ);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < `RGD_IRQ_SLOTS; i++) begin
				irq_slot[i] <= `RGD_RST_SLOT;
			end
		end else if (ce) begin
			if (slot_write) begin
				irq_slot[wdec.index][wdec.hi*32 +: 32] <=
					merge(irq_slot[wdec.index][wdec.hi*32 +: 32], w_data, w_strb);
			end
		end
	end

	// Error flags of the status word; a new error beats a clear in the same cycle
	logic status_clear;
	assign status_clear = slot_write & IRQ_RECOMMENDED & (wdec.index == `RGD_IRQ_STATUS_SLOT) & ~wdec.hi & w_strb[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fhi_err <= 1'b0;
		end else if (ce) begin
			if (fhi_write_error) begin
				fhi_err <= 1'b1;
			end else if (status_clear && w_data[`RGD_IRQ_FHIERR_BIT]) begin
				fhi_err <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eri_err <= 1'b0;
		end else if (ce) begin
			if (eri_write_error) begin
				eri_err <= 1'b1;
			end else if (status_clear && w_data[`RGD_IRQ_ERIERR_BIT]) begin
				eri_err <= 1'b0;
			end
		end
	end

	// Read channel
	rgd_decode_t rdec;
	logic [31:0] read_word;
	logic [63:0] slot_view;

	assign arready = ce & ~rvalid;
	assign rdec = decode(araddr);

	always_comb begin
		if (IRQ_RECOMMENDED && rdec.index == `RGD_IRQ_STATUS_SLOT) begin
			slot_view = irq_status;
		end else begin
			slot_view = irq_slot[rdec.index];
		end
	end

	// Reads are pure muxing, so no stored state changes on a read
	always_comb begin
		read_word = `RGD_RST_WORD;
		case (rdec.region)
			RGD_REG_GSR: begin
				read_word = summary[{rdec.index, rdec.hi, 5'h0} +: 32];
			end
			RGD_REG_IRQ: begin
				if (IRQ_PRESENT) begin
					read_word = slot_view[rdec.hi*32 +: 32];
				end
			end
			RGD_REG_AFF: begin
				read_word = aff_word[rdec.hi*32 +: 32];
			end
			RGD_REG_ARCH: begin
				read_word = arch_word;
			end
			RGD_REG_IDR: begin
				read_word = {16'h0, 16'(`RGD_NUM_RECORDS)};
			end
			RGD_REG_CID3: begin
				if (CID_PRESENT) begin
					read_word = {24'h0, `RGD_PREAMBLE_THREE};
				end
			end
			default: begin
				read_word = `RGD_RST_WORD;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= `RGD_RST_WORD;
			rresp <= `RGD_RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata <= read_word;
				rresp <= (rdec.region == RGD_REG_NONE) ? `RGD_RESP_DECERR : `RGD_RESP_OKAY;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

endmodule

// *** rtl/rgd_cfg.svh ***
`ifndef RGD_CFG_SVH
`define RGD_CFG_SVH

// Byte offsets inside the 4 KB register page
`define RGD_OFF_GSR_BASE 12'he00
`define RGD_OFF_IRQ_BASE 12'he80
`define RGD_OFF_AFF 12'hfa8
`define RGD_OFF_ARCH 12'hfbc
`define RGD_OFF_IDR 12'hfc8
`define RGD_OFF_CID3 12'hffc

// Upper address bits that select the group status and interrupt windows
`define RGD_WIN_GSR 5'h1c
`define RGD_WIN_IRQ 5'h1d

// Group size and derived counts
`define RGD_NUM_RECORDS 96
`define RGD_GSR_BITS 64
`define RGD_GSR_MAX 16
`define RGD_IRQ_SLOTS 16
`define RGD_IRQ_STATUS_SLOT 4'hf

// Fixed field values
`define RGD_PREAMBLE_THREE 8'hb1
`define RGD_FIELD_VALID 8'h80
`define RGD_FIELD_INVALID 8'h00
`define RGD_ARCH_REVISION 4'h0
`define RGD_ARCH_VERSION 4'h0

// Bit positions
`define RGD_AFF_ZERO_VALID_BIT 31
`define RGD_AFF_U_BIT 30
`define RGD_AFF_THREAD_BIT 24
`define RGD_ARCH_PRESENT_BIT 20
`define RGD_IRQ_FHI_BIT 0
`define RGD_IRQ_FHIERR_BIT 1
`define RGD_IRQ_ERI_BIT 2
`define RGD_IRQ_ERIERR_BIT 3

// Reset values
`define RGD_RST_SLOT 64'h0
`define RGD_RST_WORD 32'h0

// AXI responses
`define RGD_RESP_OKAY 2'h0
`define RGD_RESP_DECERR 2'h3

`endif

// *** rtl/rgd_pkg.sv ***
package rgd_pkg;

	typedef enum logic [1:0] {
		RGD_LAYOUT_L0,
		RGD_LAYOUT_L1,
		RGD_LAYOUT_L2,
		RGD_LAYOUT_L3
	} rgd_layout_t;

	typedef enum {
		RGD_REG_NONE,
		RGD_REG_GSR,
		RGD_REG_IRQ,
		RGD_REG_AFF,
		RGD_REG_ARCH,
		RGD_REG_IDR,
		RGD_REG_CID3
	} rgd_region_t;

	typedef struct packed {
		rgd_region_t region;
		logic [3:0] index;
		logic hi;
	} rgd_decode_t;

endpackage

// *** tb/rgd_checker.sv ***
`timescale 1ns/100ps
module rgd_checker #(
	parameter bit CID_PRESENT = 1'b1,
	parameter bit AFF_PRESENT = 1'b1,
	parameter rgd_pkg::rgd_layout_t AFF_LAYOUT = rgd_pkg::RGD_LAYOUT_L0,
	parameter bit ARCH_PRESENT = 1'b1,
	parameter bit IRQ_PRESENT = 1'b1,
	parameter logic [10:0] ARCH_DESIGNER = 11'h15a,
	parameter logic [11:0] ARCH_PART = 12'h5c3
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [11:0] awaddr,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [11:0] araddr,
	input wire logic [31:0] rdata,
	// Sources
	input wire logic [7:0] affinity_level_zero,
	input wire logic [7:0] affinity_level_one,
	input wire logic [7:0] affinity_level_two,
	input wire logic [7:0] affinity_level_three,
	input wire logic level_zero_valid_flag,
	input wire logic affinity_level_one_valid,
	input wire logic affinity_level_two_valid,
	input wire logic uniprocessor_flag,
	input wire logic threaded_interdependence_flag,
	input wire logic [95:0] record_valid,
	input wire logic [95:0] record_summary_support,
	input wire logic fhi_write_busy,
	input wire logic [127:0] fault_handling_irq_config
);
	logic take;
	logic [31:0] aff_lo, gsr_lo, gsr_mid;
	logic [7:0] aff_top, lvl_two, lvl_one, lvl_zero;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	assign take = arvalid && arready;
	// Read data reflects the sources at the edge the address is taken
	// Higher layouts trade the low level bytes for valid markers
	assign aff_top = (AFF_LAYOUT == rgd_pkg::RGD_LAYOUT_L0) ? {level_zero_valid_flag,
		uniprocessor_flag & level_zero_valid_flag, 5'h0, threaded_interdependence_flag & level_zero_valid_flag} : 8'h00;
	assign lvl_two = (AFF_LAYOUT == rgd_pkg::RGD_LAYOUT_L3) ? 8'h80 : affinity_level_two;
	assign lvl_one = (AFF_LAYOUT == rgd_pkg::RGD_LAYOUT_L2 || AFF_LAYOUT == rgd_pkg::RGD_LAYOUT_L3) ?
		{affinity_level_two_valid, 7'h0} : affinity_level_one;
	assign lvl_zero = (AFF_LAYOUT == rgd_pkg::RGD_LAYOUT_L0) ? affinity_level_zero : {affinity_level_one_valid, 7'h0};
	assign aff_lo = AFF_PRESENT ? {aff_top, lvl_two, lvl_one, lvl_zero} : 32'h0;
	assign gsr_lo = record_valid[31:0] & record_summary_support[31:0];
	assign gsr_mid = record_valid[95:64] & record_summary_support[95:64];
	chk_preamble_word: assert property (take && araddr == 12'hffc |=>
		rdata == (CID_PRESENT ? 32'h0000_00b1 : 32'h0)) else $error("preamble word wrong");
	chk_arch_word: assert property (take && araddr == 12'hfbc |=>
		rdata == (ARCH_PRESENT ? {ARCH_DESIGNER, 1'b1, 8'h00, ARCH_PART} : 32'h0)) else $error("architecture word wrong");
	chk_count_word: assert property (take && araddr == 12'hfc8 |=> rdata == 32'h0000_0060)
		else $error("record count wrong");
	chk_status_low: assert property (take && araddr == 12'he00 |=> rdata == $past(gsr_lo))
		else $error("status low word wrong");
	chk_status_mid: assert property (take && araddr == 12'he08 |=> rdata == $past(gsr_mid))
		else $error("status word two wrong");
	chk_status_top: assert property (take && araddr == 12'he0c |=> rdata == 32'h0)
		else $error("absent records not zero");
	chk_aff_low: assert property (take && araddr == 12'hfa8 |=> rdata == $past(aff_lo))
		else $error("affinity low word wrong");
	chk_aff_high: assert property (take && araddr == 12'hfac |=>
		rdata == (AFF_PRESENT ? {24'h0, $past(affinity_level_three)} : 32'h0)) else $error("affinity high word wrong");
	chk_slot_busy: assert property (take && araddr == 12'hef8 |=>
		rdata[0] == (IRQ_PRESENT & $past(fhi_write_busy))) else $error("busy bit wrong");
	chk_slot_store: assert property (awvalid && awready && wvalid && wready && awaddr == 12'he80 &&
		wstrb == 4'hf |-> ##2 fault_handling_irq_config[31:0] == (IRQ_PRESENT ? $past(wdata, 2) : 32'h0))
		else $error("slot not stored");
endmodule

// *** tb/test_ras_error_group_discovery_regs.sv ***
`timescale 1ns/100ps
module test_ras_error_group_discovery_regs;
	logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d, d2, alt_rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [7:0] affinity_level_zero, affinity_level_one, affinity_level_two, affinity_level_three;
	logic level_zero_valid_flag, affinity_level_one_valid, affinity_level_two_valid;
	logic uniprocessor_flag, threaded_interdependence_flag, fe, ee;
	logic [95:0] record_valid, record_summary_support;
	logic fhi_write_busy, eri_write_busy, fhi_write_error, eri_write_error;
	logic [127:0] fault_handling_irq_config, error_recovery_irq_config, alt_fault_cfg;
	logic [31:0] slot [32];
	int err_count, checked, seed, cyc;
	localparam logic [11:0] RO [7] = '{12'hffc, 12'hfbc, 12'hfc8, 12'hfa8, 12'hfac, 12'he00, 12'he0c};
	localparam logic [11:0] RD [6] = '{12'he00, 12'he04, 12'he08, 12'he0c, 12'hfa8, 12'hfac};

	rgd_regs DUT (.*);

	// Second build with the preamble, architecture and interrupt words absent and the level-3 affinity layout; same bus, same timing
	rgd_regs #(.CID_PRESENT(1'b0), .AFF_LAYOUT(rgd_pkg::RGD_LAYOUT_L3), .ARCH_PRESENT(1'b0), .IRQ_PRESENT(1'b0))
		DUT_ALT (.*, .awready(), .wready(), .bvalid(), .bresp(), .arready(), .rvalid(), .rdata(alt_rdata),
		.rresp(), .fault_handling_irq_config(alt_fault_cfg), .error_recovery_irq_config());

	initial begin
		aclk = 0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task print_verdict;
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Cuts a hang short; the full run needs under a thousand cycles
	always @(posedge aclk) begin
		cyc++;
		if (cyc > 8000) begin
			err_count++;
			print_verdict;
		end
	end

	task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
		logic ad, wd;
		ad = 0;
		wd = 0;
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awvalid && awready) ad = 1;
			if (wvalid && wready) wd = 1;
			awvalid <= !ad;
			wvalid <= !wd;
		end
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [11:0] a);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		d2 = alt_rdata;
		r = rresp;
		rready <= 0;
		@(posedge aclk);
	endtask

	function automatic logic [31:0] exp_rd(input logic [11:0] a);
		logic [127:0] t;
		t = {32'h0, record_valid & record_summary_support} >> (32 * a[3:2]);
		case (a)
			12'hffc: return 32'h0000_00b1;
			12'hfc8: return 32'h0000_0060;
			12'hfbc: return {11'h15a, 1'b1, 8'h00, 12'h5c3};
			12'hfa8: return {level_zero_valid_flag, uniprocessor_flag & level_zero_valid_flag, 5'h0,
				threaded_interdependence_flag & level_zero_valid_flag, affinity_level_two, affinity_level_one,
				affinity_level_zero};
			12'hfac: return {24'h0, affinity_level_three};
			12'hef8: return {28'h0, ee, eri_write_busy, fe, fhi_write_busy};
			default: return (a[11:7] == 5'h1c) ? t[31:0] : slot[a[6:2]];
		endcase
	endfunction

	function automatic logic [31:0] exp_alt(input logic [11:0] a);
		case (a)
			12'hffc, 12'hfbc: return 32'h0;
			12'hfa8: return {16'h0080, affinity_level_two_valid ? 8'h80 : 8'h00,
				affinity_level_one_valid ? 8'h80 : 8'h00};
			default: return (a[11:7] == 5'h1d) ? 32'h0 : exp_rd(a);
		endcase
	endfunction

	task automatic rnd(input bit ones);
		record_valid <= ones ? '1 : {$random(seed), $random(seed), $random(seed)};
		record_summary_support <= ones ? '1 : {$random(seed), $random(seed), $random(seed)};
		{affinity_level_three, affinity_level_two, affinity_level_one, affinity_level_zero} <= $random(seed);
		{level_zero_valid_flag, uniprocessor_flag, threaded_interdependence_flag} <= 3'($random(seed));
		{fhi_write_busy, eri_write_busy, affinity_level_one_valid, affinity_level_two_valid} <= 4'($random(seed));
		@(posedge aclk);
	endtask

	initial begin
		logic [31:0] w;
		logic [3:0] s;
		int k;
		seed = 69;
		{aresetn, ce, awvalid, wvalid, bready, arvalid, rready, fhi_write_error, eri_write_error, fe, ee} = 0;
		{awaddr, araddr, wdata, wstrb, record_valid, record_summary_support} = 0;
		{affinity_level_three, affinity_level_two, affinity_level_one, affinity_level_zero} = 0;
		{level_zero_valid_flag, uniprocessor_flag, threaded_interdependence_flag} = 0;
		{fhi_write_busy, eri_write_busy, affinity_level_one_valid, affinity_level_two_valid} = 0;
		ce = 1;
		foreach (slot[i]) slot[i] = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		rnd(0);
		foreach (RO[i]) begin
			rd(RO[i]);
			chk(d, exp_rd(RO[i]));
			chk(d2, exp_alt(RO[i]));
			wr(RO[i], 32'hffff_ffff, 4'hf);
			chk(32'(r), 32'h0);
			rd(RO[i]);
			chk(d, exp_rd(RO[i]));
		end
		rd(12'he10);
		chk(d, 32'h0);
		chk(32'(r), 32'h3);
		wr(12'he10, 32'hffff_ffff, 4'hf);
		chk(32'(r), 32'h3);
		slot[0] = 32'h1234_5678;
		wr(12'he80, slot[0], 4'hf);
		for (int i = 0; i < 30; i++) begin
			rnd(i == 0);
			foreach (RD[j]) begin
				rd(RD[j]);
				chk(d, exp_rd(RD[j]));
				chk(d2, exp_alt(RD[j]));
			end
			k = {$random(seed)} % 30;
			w = $random(seed);
			s = 4'($random(seed));
			wr(12'he80 + 12'(4 * k), w, s);
			for (int b = 0; b < 4; b++) if (s[b]) slot[k][8 * b +: 8] = w[8 * b +: 8];
			rd(12'he80 + 12'(4 * k));
			chk(d, exp_rd(12'he80 + 12'(4 * k)));
			chk(d2, 32'h0);
			chk(32'(|alt_fault_cfg), 32'h0);
			for (int j = 0; j < 4; j++) begin
				chk(fault_handling_irq_config[32 * j +: 32], slot[j]);
				chk(error_recovery_irq_config[32 * j +: 32], slot[4 + j]);
			end
		end
		// Error pulses are one cycle wide and must stick until cleared
		fhi_write_error <= 1;
		eri_write_error <= 1;
		@(posedge aclk);
		{fhi_write_error, eri_write_error} <= 2'b00;
		{fe, ee} = 2'b11;
		rd(12'hef8);
		chk(d, exp_rd(12'hef8));
		wr(12'hef8, 32'h2, 4'h1);
		fe = 0;
		rd(12'hef8);
		chk(d, exp_rd(12'hef8));
		wr(12'hef8, 32'h8, 4'h1);
		ee = 0;
		rd(12'hef8);
		chk(d, exp_rd(12'hef8));
		// Error pulses while the enable is low must leave the sticky bits clear
		ce <= 0;
		{fhi_write_error, eri_write_error} <= 2'b11;
		@(posedge aclk);
		{fhi_write_error, eri_write_error} <= 2'b00;
		ce <= 1;
		rd(12'hef8);
		chk(d, exp_rd(12'hef8));
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		foreach (slot[i]) slot[i] = 0;
		rd(12'he80);
		chk(d, 32'h0);
		print_verdict;
	end
endmodule

bind rgd_regs rgd_checker #(.CID_PRESENT(CID_PRESENT), .AFF_PRESENT(AFF_PRESENT), .AFF_LAYOUT(AFF_LAYOUT),
	.ARCH_PRESENT(ARCH_PRESENT), .IRQ_PRESENT(IRQ_PRESENT), .ARCH_DESIGNER(ARCH_DESIGNER), .ARCH_PART(ARCH_PART))
	CHK (.*);
